// *** src/serial_rtc_device.sv ***
// Two-wire slave front end with register pointer and burst access
`timescale 1ns/1ps
module serial_rtc_device #(
	parameter int unsigned DEPTH = 2
) (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       ce,
	input  wire logic       clk_link,
	serial_rtc_if.device    bus,
	output logic            wr_valid,
	input  wire logic       wr_ready,
	output logic [7:0]      wr_addr,
	output logic [7:0]      wr_data,
	output logic [7:0]      rd_addr,
	input  wire logic [7:0] rd_data
);
	import serial_rtc_pkg::*;

	localparam int unsigned IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	////////////////////////////////////////////////////////////////////////
	// State of both domains
	typedef struct packed {
		logic       rst_s1;
		logic       rst_s2;
		logic       scl_s1;
		logic       scl_s2;
		logic       scl_p;
		logic       sda_s1;
		logic       sda_s2;
		logic       sda_p;
		logic       ack_s1;
		logic       ack_s2;
		logic       ack_p;
		dstate_t    state;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic       rw;
		logic       ptr_phase;
		logic [7:0] ptr;
		logic       sda_oe;
		logic [7:0] tx_byte;
		logic       pend;
		logic       pend_wr;
		logic [7:0] pend_addr;
		logic [7:0] pend_data;
		logic       busy;
		logic       req_t;
		logic       req_wr;
		logic [7:0] req_addr;
		logic [7:0] req_data;
	} lnk_t;

	typedef struct packed {
		logic                       req_s1;
		logic                       req_s2;
		logic                       req_seen;
		logic                       job;
		logic                       kind;
		logic [7:0]                 addr;
		logic [7:0]                 data;
		logic                       ack_t;
		logic [7:0]                 ans_data;
		logic [DEPTH-1:0][7:0]      buf_addr;
		logic [DEPTH-1:0][7:0]      buf_data;
		logic [IW-1:0]              wr_i;
		logic [IW-1:0]              rd_i;
		logic [IW:0]                count;
	} sys_t;

	lnk_t l_reg;
	lnk_t l_next;
	sys_t s_reg;
	sys_t s_next;
	logic rise;
	logic fall;
	logic start_c;
	logic stop_c;
	logic push;
	logic pop;

	function automatic logic [IW-1:0] idx_inc(input logic [IW-1:0] i);
		idx_inc = (i == IW'(DEPTH - 1)) ? '0 : i + IW'(1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Link domain: pin sampling and serial engine
	always_comb begin
		l_next = l_reg;
		l_next.rst_s1 = reset;
		l_next.rst_s2 = l_reg.rst_s1;
		l_next.scl_s1 = bus.scl;
		l_next.scl_s2 = l_reg.scl_s1;
		l_next.scl_p = l_reg.scl_s2;
		l_next.sda_s1 = bus.sda;
		l_next.sda_s2 = l_reg.sda_s1;
		l_next.sda_p = l_reg.sda_s2;
		l_next.ack_s1 = s_reg.ack_t;
		l_next.ack_s2 = l_reg.ack_s1;
		l_next.ack_p = l_reg.ack_s2;
		rise = l_reg.scl_s2 & ~l_reg.scl_p;
		fall = ~l_reg.scl_s2 & l_reg.scl_p;
		start_c = l_reg.scl_s2 & l_reg.scl_p & l_reg.sda_p & ~l_reg.sda_s2;
		stop_c = l_reg.scl_s2 & l_reg.scl_p & ~l_reg.sda_p & l_reg.sda_s2;

		// Answer from the system side
		if (l_reg.ack_s2 != l_reg.ack_p) begin
			l_next.busy = 1'h0;
			l_next.tx_byte = s_reg.ans_data;
		end

		if (start_c) begin
			l_next.state = D_ADDR;
			l_next.cnt = 4'h0;
			l_next.sda_oe = 1'h0;
		end else if (stop_c) begin
			l_next.state = D_IDLE;
			l_next.sda_oe = 1'h0;
		end else begin
			case (l_reg.state)
			D_ADDR: begin
				if (rise) begin
					l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
					l_next.cnt = l_reg.cnt + 4'h1;
				end else if (fall && l_reg.cnt == BYTE_BITS) begin
					if (l_reg.shift[7:1] == DEV_ADDR) begin
						l_next.sda_oe = 1'h1;
						l_next.rw = l_reg.shift[0];
						l_next.ptr_phase = (l_reg.shift[0] == RW_WRITE);
						l_next.state = D_ACK;
						if (l_reg.shift[0] == RW_READ) begin
							l_next.pend = 1'h1;
							l_next.pend_wr = 1'h0;
							l_next.pend_addr = l_reg.ptr;
						end
					end else begin
						l_next.state = D_SKIP;
					end
				end
			end
			D_RX: begin
				if (rise) begin
					l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
					l_next.cnt = l_reg.cnt + 4'h1;
				end else if (fall && l_reg.cnt == BYTE_BITS) begin
					l_next.sda_oe = 1'h1;
					l_next.state = D_ACK;
					if (l_reg.ptr_phase) begin
						l_next.ptr = l_reg.shift;
						l_next.ptr_phase = 1'h0;
					end else begin
						l_next.pend = 1'h1;
						l_next.pend_wr = 1'h1;
						l_next.pend_addr = l_reg.ptr;
						l_next.pend_data = l_reg.shift;
						l_next.ptr = l_reg.ptr + 8'h01;
					end
				end
			end
			D_ACK: begin
				if (fall) begin
					l_next.cnt = 4'h0;
					if (l_reg.rw == RW_READ) begin
						l_next.shift = l_next.tx_byte;
						l_next.sda_oe = ~l_next.tx_byte[7];
						l_next.state = D_TX;
					end else begin
						l_next.sda_oe = 1'h0;
						l_next.state = D_RX;
					end
				end
			end
			D_TX: begin
				if (fall) begin
					l_next.cnt = l_reg.cnt + 4'h1;
					if (l_reg.cnt == LAST_BIT) begin
						l_next.sda_oe = 1'h0;
						l_next.state = D_MACK;
						l_next.ptr = l_reg.ptr + 8'h01;
						l_next.pend = 1'h1;
						l_next.pend_wr = 1'h0;
						l_next.pend_addr = l_reg.ptr + 8'h01;
					end else begin
						l_next.shift = {l_reg.shift[6:0], 1'h0};
						l_next.sda_oe = ~l_reg.shift[6];
					end
				end
			end
			D_MACK: begin
				if (rise && l_reg.sda_s2) begin
					l_next.state = D_SKIP;
				end else if (fall) begin
					l_next.cnt = 4'h0;
					l_next.shift = l_next.tx_byte;
					l_next.sda_oe = ~l_next.tx_byte[7];
					l_next.state = D_TX;
				end
			end
			D_SKIP: l_next.sda_oe = 1'h0;
			D_IDLE: l_next.sda_oe = 1'h0;
			default: l_next.state = D_IDLE;
			endcase
		end

		// Launch one request to the system side
		if (l_next.pend && !l_next.busy) begin
			l_next.req_t = ~l_reg.req_t;
			l_next.req_wr = l_next.pend_wr;
			l_next.req_addr = l_next.pend_addr;
			l_next.req_data = l_next.pend_data;
			l_next.busy = 1'h1;
			l_next.pend = 1'h0;
		end

		if (l_reg.rst_s2) begin
			l_next.state = D_IDLE;
			l_next.sda_oe = 1'h0;
			l_next.ptr = PTR_RESET;
			l_next.pend = 1'h0;
			l_next.busy = 1'h0;
			l_next.req_t = 1'h0;
			l_next.ack_p = l_reg.ack_s2;
		end
	end

	always_ff @(posedge clk_link) begin
		l_reg <= l_next;
	end

	////////////////////////////////////////////////////////////////////////
	// System domain: request service and DEPTH-entry write buffer
	always_comb begin
		s_next = s_reg;
		s_next.req_s1 = l_reg.req_t;
		s_next.req_s2 = s_reg.req_s1;
		push = 1'h0;
		pop = wr_ready && (s_reg.count != '0);
		if (s_reg.job) begin
			if (!s_reg.kind) begin
				s_next.ans_data = rd_data;
				s_next.ack_t = ~s_reg.ack_t;
				s_next.job = 1'h0;
			end else if (s_reg.count != (IW + 1)'(DEPTH)) begin
				push = 1'h1;
				s_next.ack_t = ~s_reg.ack_t;
				s_next.job = 1'h0;
			end
		end else if (s_reg.req_s2 != s_reg.req_seen) begin
			s_next.req_seen = s_reg.req_s2;
			s_next.job = 1'h1;
			s_next.kind = l_reg.req_wr;
			s_next.addr = l_reg.req_addr;
			s_next.data = l_reg.req_data;
		end
		if (push) begin
			s_next.buf_addr[s_reg.wr_i] = s_reg.addr;
			s_next.buf_data[s_reg.wr_i] = s_reg.data;
			s_next.wr_i = idx_inc(s_reg.wr_i);
		end
		if (pop)
			s_next.rd_i = idx_inc(s_reg.rd_i);
		if (push && !pop)
			s_next.count = s_reg.count + (IW + 1)'(1);
		else if (pop && !push)
			s_next.count = s_reg.count - (IW + 1)'(1);
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			s_reg <= '0;
		else if (ce)
			s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign wr_valid = (s_reg.count != '0);
	assign wr_addr = s_reg.buf_addr[s_reg.rd_i];
	assign wr_data = s_reg.buf_data[s_reg.rd_i];
	assign rd_addr = s_reg.addr;
	assign bus.sda_o_d = 1'h0;
	assign bus.sda_oe_d = l_reg.sda_oe;
endmodule

// *** src/serial_rtc_pkg.sv ***
// Shared constants and types for the two-wire clock register link
package serial_rtc_pkg;

	// Bus addressing
	localparam logic [6:0] DEV_ADDR     = 7'h68;
	localparam logic       RW_WRITE     = 1'h0;
	localparam logic       RW_READ      = 1'h1;
	localparam logic [3:0] LAST_BIT     = 4'h7;
	localparam logic [3:0] BYTE_BITS    = 4'h8;
	localparam logic [7:0] PTR_RESET    = 8'h00;

	// Bit timing of the master
	localparam int unsigned CLK_SYS_HZ  = 250_000_000;
	localparam int unsigned SCL_STD_HZ  = 100_000;
	localparam int unsigned SCL_FAST_HZ = 400_000;
	localparam int unsigned QTR_CYCLES  = CLK_SYS_HZ / (4 * SCL_FAST_HZ);

	// Master commands
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_STOP  = 2'h1,
		OP_WRITE = 2'h2,
		OP_READ  = 2'h3
	} op_t;

	// Device serial engine states
	typedef enum logic [6:0] {
		D_IDLE = 7'h01,
		D_ADDR = 7'h02,
		D_ACK  = 7'h04,
		D_RX   = 7'h08,
		D_TX   = 7'h10,
		D_MACK = 7'h20,
		D_SKIP = 7'h40
	} dstate_t;

	// Master states
	typedef enum logic [1:0] {
		M_IDLE = 2'h1,
		M_RUN  = 2'h2
	} mstate_t;

endpackage

// *** src/serial_rtc_if.sv ***
// Open-drain two-wire bus joining master and device
`timescale 1ns/1ps
interface serial_rtc_if;
	logic scl_o_m;
	logic scl_oe_m;
	logic sda_o_m;
	logic sda_oe_m;
	logic sda_o_d;
	logic sda_oe_d;
	logic scl;
	logic sda;

	// Wired-AND with pull-up
	assign scl = scl_oe_m ? scl_o_m : 1'h1;
	assign sda = (sda_oe_m ? sda_o_m : 1'h1) & (sda_oe_d ? sda_o_d : 1'h1);

	modport master (
		output scl_o_m,
		output scl_oe_m,
		output sda_o_m,
		output sda_oe_m,
		input  scl,
		input  sda
	);

	modport device (
		output sda_o_d,
		output sda_oe_d,
		input  scl,
		input  sda
	);
endinterface

// *** src/serial_rtc_master.sv ***
// Two-wire bus master issuing start, stop and byte commands
`timescale 1ns/1ps
module serial_rtc_master #(
	parameter int unsigned QTR = serial_rtc_pkg::QTR_CYCLES
) (
	input  wire logic                clk_sys,
	input  wire logic                reset,
	input  wire logic                ce,
	serial_rtc_if.master             bus,
	input  wire logic                cmd_valid,
	output logic                     cmd_ready,
	input  wire serial_rtc_pkg::op_t cmd_op,
	input  wire logic [7:0]          cmd_data,
	input  wire logic                cmd_last,
	output logic                     rsp_valid,
	output logic [7:0]               rsp_data,
	output logic                     rsp_nack
);
	import serial_rtc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		mstate_t     state;
		op_t         op;
		logic        last;
		logic [1:0]  q;
		logic [3:0]  bitn;
		logic [15:0] cnt;
		logic [7:0]  shift;
		logic        scl_oe;
		logic        sda_oe;
		logic        sda_s1;
		logic        sda_s2;
		logic        rsp_valid;
		logic [7:0]  rsp_data;
		logic        rsp_nack;
	} mst_t;

	mst_t r_reg;
	mst_t r_next;
	logic is_data;

	////////////////////////////////////////////////////////////////////////
	// Quarter-bit sequencer
	always_comb begin
		r_next = r_reg;
		r_next.sda_s1 = bus.sda;
		r_next.sda_s2 = r_reg.sda_s1;
		r_next.rsp_valid = 1'h0;
		is_data = (r_reg.bitn != BYTE_BITS);
		case (r_reg.state)
		M_IDLE: begin
			if (cmd_valid) begin
				r_next.state = M_RUN;
				r_next.op = cmd_op;
				r_next.last = cmd_last;
				r_next.shift = cmd_data;
				r_next.q = 2'h0;
				r_next.bitn = 4'h0;
				r_next.cnt = 16'h0000;
				r_next.scl_oe = 1'h1;
			end
		end
		M_RUN: begin
			if (r_reg.cnt == 16'(QTR - 1)) begin
				r_next.cnt = 16'h0000;
				r_next.q = r_reg.q + 2'h1;
				case (r_reg.q)
				2'h0: begin
					case (r_reg.op)
					OP_START: r_next.sda_oe = 1'h0;
					OP_STOP:  r_next.sda_oe = 1'h1;
					OP_WRITE: r_next.sda_oe = is_data & ~r_reg.shift[7];
					default:  r_next.sda_oe = ~is_data & ~r_reg.last;
					endcase
				end
				2'h1: r_next.scl_oe = 1'h0;
				2'h2: begin
					case (r_reg.op)
					OP_START: r_next.sda_oe = 1'h1;
					OP_STOP:  r_next.sda_oe = 1'h0;
					default: begin
						if (is_data)
							r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
						else if (r_reg.op == OP_WRITE)
							r_next.rsp_nack = r_reg.sda_s2;
						else
							r_next.rsp_nack = r_reg.last;
					end
					endcase
				end
				default: begin
					if (r_reg.op == OP_START || r_reg.op == OP_STOP ||
					    !is_data) begin
						r_next.state = M_IDLE;
						r_next.rsp_valid = 1'h1;
						r_next.rsp_data = r_reg.shift;
					end else begin
						r_next.bitn = r_reg.bitn + 4'h1;
						r_next.scl_oe = 1'h1;
					end
				end
				endcase
			end else begin
				r_next.cnt = r_reg.cnt + 16'h0001;
			end
		end
		default: r_next.state = M_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r_reg <= '0;
			r_reg.state <= M_IDLE;
			r_reg.op <= OP_START;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign cmd_ready = (r_reg.state == M_IDLE);
	assign rsp_valid = r_reg.rsp_valid;
	assign rsp_data = r_reg.rsp_data;
	assign rsp_nack = r_reg.rsp_nack;
	assign bus.scl_o_m = 1'h0;
	assign bus.scl_oe_m = r_reg.scl_oe;
	assign bus.sda_o_m = 1'h0;
	assign bus.sda_oe_m = r_reg.sda_oe;
endmodule

// *** verif/serial_rtc_monitor.sv ***
// Checker of the two-wire link between master and device
`timescale 1ns/1ps
module serial_rtc_monitor (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_oe_d,
	input wire logic sda_oe_m
);
	import serial_rtc_pkg::*;
	logic       scl_q;
	logic       sda_q;
	logic       quiet;
	logic [3:0] bit_cnt;
	logic [1:0] byte_no;
	logic [7:0] shreg;
	logic [7:0] addr;
	wire        rise  = scl && !scl_q;
	wire        start = scl && scl_q && sda_q && !sda;
	wire        stop  = scl && scl_q && !sda_q && sda;

	////////////////////////////////
	// Bit and byte position tracking
	always_ff @(posedge clk_sys) begin
		scl_q <= scl;
		sda_q <= sda;
		if (reset) begin
			bit_cnt <= 4'h0;
			byte_no <= 2'h0;
			quiet   <= 1'b1;
		end else if (start) begin
			bit_cnt <= 4'h0;
			byte_no <= 2'h0;
			quiet   <= 1'b0;
		end else if (stop) begin
			quiet <= 1'b1;
		end else if (rise && bit_cnt == BYTE_BITS) begin
			bit_cnt <= 4'h0;
			if (byte_no != 2'h2) begin
				byte_no <= byte_no + 2'h1;
			end
			if (byte_no == 2'h0 && addr[7:1] != DEV_ADDR) begin
				quiet <= 1'b1;
			end
			if (byte_no != 2'h0 && addr[0] == RW_READ && sda) begin
				quiet <= 1'b1;
			end
		end else if (rise) begin
			bit_cnt <= bit_cnt + 4'h1;
			shreg   <= {shreg[6:0], sda};
			if (byte_no == 2'h0 && bit_cnt == LAST_BIT) begin
				addr <= {shreg[6:0], sda};
			end
		end
	end

	////////////////////////////////
	// Properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence ack_rise;
		rise && bit_cnt == BYTE_BITS;
	endsequence

	a_addr_ack: assert property (ack_rise ##0 (byte_no == 2'h0 &&
		addr[7:1] == DEV_ADDR) |-> sda_oe_d && !sda)
		else $error("own address not acknowledged");
	a_foreign_quiet: assert property (ack_rise ##0 (byte_no == 2'h0 &&
		addr[7:1] != DEV_ADDR) |-> !sda_oe_d)
		else $error("foreign address acknowledged");
	a_write_ack: assert property (ack_rise ##0 (byte_no != 2'h0 &&
		addr[0] == RW_WRITE && !quiet) |-> sda_oe_d)
		else $error("written byte not acknowledged");
	a_read_ack_free: assert property (ack_rise ##0 (byte_no != 2'h0 &&
		addr[0] == RW_READ) |-> !sda_oe_d)
		else $error("device holds line in master ack");
	a_read_master_off: assert property (rise && bit_cnt < BYTE_BITS &&
		byte_no != 2'h0 && addr[0] == RW_READ && !quiet |-> !sda_oe_m)
		else $error("master drives read data bit");
	a_quiet_release: assert property (quiet |-> !sda_oe_d)
		else $error("device drives while not addressed");
	a_stable_high: assert property ($changed(sda_oe_d) |-> !scl)
		else $error("device changes data while clock high");
	a_addr_silent: assert property (byte_no == 2'h0 &&
		bit_cnt < BYTE_BITS && !quiet |-> !sda_oe_d)
		else $error("device drives during address byte");
endmodule

// *** verif/rtc_serial_register_access_tb.sv ***
// Self-checking bench joining master and device
`timescale 1ns/1ps
module rtc_serial_register_access_tb;
	import serial_rtc_pkg::*;
	logic        clk_sys   = 1'b0;
	logic        clk_link  = 1'b0;
	logic        reset     = 1'b1;
	logic        cmd_valid = 1'b0;
	logic        cmd_last  = 1'b0;
	logic        wr_ready  = 1'b0;
	op_t         cmd_op    = OP_START;
	logic [7:0]  cmd_data  = 8'h00;
	logic        cmd_ready, rsp_valid, rsp_nack, wr_valid;
	logic [7:0]  rsp_data, wr_addr, wr_data, rd_addr, ptr, p;
	logic [7:0]  mem [256];
	logic [7:0]  exp_mem [256];
	logic [15:0] wq [$];
	int          err_count = 0;
	int          checks_done = 0;
	int          cyc = 0;

	serial_rtc_if serial_rtc_if_inst ();
	serial_rtc_master #(.QTR(48)) serial_rtc_master_inst (.clk_sys(clk_sys),
		.reset(reset), .ce(1'b1), .bus(serial_rtc_if_inst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_nack(rsp_nack));
	serial_rtc_device #(.DEPTH(2)) serial_rtc_device_inst (.clk_sys(clk_sys),
		.reset(reset), .ce(1'b1), .clk_link(clk_link),
		.bus(serial_rtc_if_inst), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
		.rd_data(mem[rd_addr]));
	serial_rtc_monitor serial_rtc_monitor_inst (.clk_sys(clk_sys),
		.reset(reset), .scl(serial_rtc_if_inst.scl),
		.sda(serial_rtc_if_inst.sda), .sda_oe_d(serial_rtc_if_inst.sda_oe_d),
		.sda_oe_m(serial_rtc_if_inst.sda_oe_m));

	always #2 clk_sys = ~clk_sys;
	initial begin
		#7;
		forever #40 clk_link = ~clk_link;
	end

	////////////////////////////////
	// Tasks
	task automatic check(input string nm, input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	function automatic logic [15:0] exp_byte(input logic [7:0] a);
		return {8'h00, exp_mem[a]};
	endfunction

	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmd(input op_t op, input logic [7:0] d, input logic last);
		int n;
		n = 0;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_op    <= op;
		cmd_data  <= d;
		cmd_last  <= last;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cmd_ready !== 1'b1 && n < 9000);
		cmd_valid <= 1'b0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rsp_valid !== 1'b1 && n < 9000);
		if (n >= 9000) begin
			err_count++;
			final_report();
		end
	endtask

	task automatic wr_burst(input logic [7:0] pa, input int n);
		logic [7:0] d;
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, {DEV_ADDR, RW_WRITE}, 1'b0);
		check("wr_addr_ack", 16'(rsp_nack), 16'h0000);
		cmd(OP_WRITE, pa, 1'b0);
		check("ptr_ack", 16'(rsp_nack), 16'h0000);
		ptr = pa;
		repeat (n) begin
			d = 8'($urandom);
			wq.push_back({ptr, d});
			exp_mem[ptr] = d;
			cmd(OP_WRITE, d, 1'b0);
			check("data_ack", 16'(rsp_nack), 16'h0000);
			check("wr_echo", {8'h00, rsp_data}, {8'h00, d});
			ptr++;
		end
		cmd(OP_STOP, 8'h00, 1'b0);
	endtask

	task automatic rd_burst(input logic set, input logic [7:0] pa, input int n);
		cmd(OP_START, 8'h00, 1'b0);
		if (set) begin
			cmd(OP_WRITE, {DEV_ADDR, RW_WRITE}, 1'b0);
			cmd(OP_WRITE, pa, 1'b0);
			ptr = pa;
			cmd(OP_START, 8'h00, 1'b0);
		end
		cmd(OP_WRITE, {DEV_ADDR, RW_READ}, 1'b0);
		check("rd_addr_ack", 16'(rsp_nack), 16'h0000);
		for (int i = 0; i < n; i++) begin
			cmd(OP_READ, 8'h00, i == n - 1);
			check("rd_byte", {8'h00, rsp_data}, exp_byte(ptr));
			ptr++;
		end
		cmd(OP_STOP, 8'h00, 1'b0);
	endtask

	////////////////////////////////
	// Register store and timeout
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		wr_ready <= ($urandom % 4) != 0;
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			check("wr_pair", {wr_addr, wr_data}, wq.pop_front());
			mem[wr_addr] <= wr_data;
		end
		if (cyc == 90000) begin
			err_count++;
			final_report();
		end
	end

	////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(84));
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'($urandom);
			exp_mem[i] = mem[i];
		end
		repeat (80) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (100) @(posedge clk_sys);
		wr_burst(8'hFE, 3);
		rd_burst(1'b0, 8'h00, 3);
		rd_burst(1'b1, 8'hFE, 3);
		cmd(OP_START, 8'h00, 1'b0);
		cmd(OP_WRITE, 8'hD2, 1'b0);
		check("foreign_ack", 16'(rsp_nack), 16'h0001);
		cmd(OP_WRITE, 8'($urandom), 1'b0);
		check("foreign_data", 16'(rsp_nack), 16'h0001);
		cmd(OP_STOP, 8'h00, 1'b0);
		rd_burst(1'b0, 8'h00, 2);
		p = 8'($urandom);
		wr_burst(p, 0);
		rd_burst(1'b0, 8'h00, 1);
		p = 8'($urandom);
		wr_burst(p, 2);
		rd_burst(1'b1, p, 2);
		repeat (50) @(posedge clk_sys);
		check("queue_left", 16'(wq.size()), 16'h0000);
		final_report();
	end
endmodule
